// ### verilog/asr_cfg.svh
/*
 * Constants of the converter configuration register bank: offsets, reset values,
 * field positions and frame lengths. Assumes inclusion by bare name from verilog/.
 */
`ifndef ASR_CFG_SVH
`define ASR_CFG_SVH

// ----------------------------------------
// register offsets (13-bit address field)
// ----------------------------------------
`define ASR_ADDR_W 13
`define ASR_ADDR_PORTCFG 13'h0000
`define ASR_ADDR_PARTID 13'h0001
`define ASR_ADDR_GRADE 13'h0002
`define ASR_ADDR_CHSEL 13'h0005
`define ASR_ADDR_LOCAL 13'h0014
`define ASR_ADDR_STEP 13'h0001

// ----------------------------------------
// reset values and masks
// ----------------------------------------
`define ASR_PORTCFG_RST 8'h18
`define ASR_CHSEL_RST 8'h33
`define ASR_CHSEL_MASK 8'h33
`define ASR_LOCAL_RST 8'h00
`define ASR_ZERO_BYTE 8'h00
`define ASR_GRADE_LSB 4

// ----------------------------------------
// field positions
// ----------------------------------------
`define ASR_SOFT_HI 5
`define ASR_SOFT_LO 2
`define ASR_LSB_HI 6
`define ASR_LSB_LO 1
`define ASR_SEL_A 0
`define ASR_SEL_B 1
`define ASR_SEL_FRAME_CLK 4
`define ASR_SEL_DATA_CLK 5
`define ASR_RW_POS 14

// ----------------------------------------
// frame lengths
// ----------------------------------------
`define ASR_INSTR_LAST 4'hF
`define ASR_BYTE_LAST 4'h7
`define ASR_CNT_ZERO 4'h0
`define ASR_CNT_STEP 4'h1
`define ASR_NUM_COPIES 4

`endif

// ### verilog/asr_pkg.sv
/*
 * Types shared by the register bank modules.
 * Assumes asr_cfg.svh is available on the include path.
 */
`default_nettype none
package asr_pkg;
    // ----------------------------------------
    // serial frame phases
    // ----------------------------------------
    typedef enum logic [1:0] {
        ASR_IDLE = 2'h0,
        ASR_INSTR = 2'h1,
        ASR_DATA = 2'h2
    } asr_state_t;
endpackage
`default_nettype wire

// ### verilog/asr_local_if.sv
/*
 * Carrier between the serial controller and the per-channel register copies.
 * Assumes both ends run on mclk with the synchronised reset.
 */
`timescale 1ns/100ps
`default_nettype none
interface asr_local_if;
    logic wrLocal;
    logic [7:0] wrData;
    logic [3:0] selVec;
    logic softRst;
    logic [7:0] rdData;
    modport ctrl (output wrLocal, output wrData, output selVec, output softRst, input rdData);
    modport bank (input wrLocal, input wrData, input selVec, input softRst, output rdData);
endinterface
`default_nettype wire

// ### verilog/asr_local_bank.sv
/*
 * Per-channel copies of the local setup register: data A, data B, frame clock,
 * data clock. Assumes selVec order {data clock, frame clock, b, a} and a one-cycle
 * write strobe.
 */
`timescale 1ns/100ps
`default_nettype none
`include "asr_cfg.svh"
module asr_local_bank (
    input wire logic mclk,
    input wire logic rstSync_b,
    asr_local_if.bank lcl,
    output logic [3:0][7:0] copies
);
    // ----------------------------------------
    // replicated storage
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < `ASR_NUM_COPIES; i = i + 1) begin : g_copy
            wire hit = lcl.wrLocal && lcl.selVec[i];
            always_ff @(posedge mclk or negedge rstSync_b) begin
                if (!rstSync_b)
                    copies[i] <= `ASR_LOCAL_RST;
                else if (lcl.softRst)
                    copies[i] <= `ASR_LOCAL_RST;
                else if (hit)
                    copies[i] <= lcl.wrData;
            end
        end
    endgenerate

    // ----------------------------------------
    // readback: data channel A wins
    // ----------------------------------------
    assign lcl.rdData = lcl.selVec[0] ? copies[0] :
                        lcl.selVec[1] ? copies[1] :
                        lcl.selVec[2] ? copies[2] :
                        lcl.selVec[3] ? copies[3] : `ASR_ZERO_BYTE;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstSync_b);

    AST_ALL_COPIES: assert property (
        lcl.wrLocal && (&lcl.selVec) && !lcl.softRst |=> copies[0] == $past(lcl.wrData)
            && copies[1] == copies[0] && copies[2] == copies[0] && copies[3] == copies[0])
        else $error("broadcast write missed a copy");
    AST_UNSEL_KEEP: assert property (
        lcl.wrLocal && !lcl.selVec[1] && !lcl.softRst |=> $stable(copies[1]))
        else $error("unselected copy changed");
    AST_READ_A: assert property (
        lcl.selVec[0] |-> lcl.rdData == copies[0])
        else $error("read did not return channel A copy");
endmodule // asr_local_bank
`default_nettype wire

// ### verilog/asr_spi_regs.sv
/*
 * Configuration register bank of a dual converter behind a 3-wire serial port
 * with 16-bit instructions. Serial pins are sampled on mclk; each serial clock
 * phase must last at least two mclk periods.
 */
`timescale 1ns/100ps
`default_nettype none
`include "asr_cfg.svh"
module asr_spi_regs #(
    parameter logic [7:0] PART_ID = 8'h5A, // arbitrary value
    parameter logic [2:0] SPEED_GRADE = 3'h0 // arbitrary value
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic serialShiftClock,
    input wire logic portSelectLow,
    input wire logic sharedSerialLineIn,
    output logic sharedSerialLineOut,
    output logic sharedSerialLineOeN,
    output logic [7:0] channelSelect,
    output logic lsbFirst,
    output logic [3:0][7:0] channelSetup
);
    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic rstMeta_b;
    logic rstSync_b;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rstMeta_b <= 1'b0;
            rstSync_b <= 1'b0;
        end else begin
            rstMeta_b <= 1'b1;
            rstSync_b <= rstMeta_b;
        end
    end

    // ----------------------------------------
    // serial clock edges
    // ----------------------------------------
    logic sclkPrev;
    always_ff @(posedge mclk or negedge rstSync_b) begin
        if (!rstSync_b)
            sclkPrev <= 1'b0;
        else
            sclkPrev <= serialShiftClock;
    end
    wire sclkRise = serialShiftClock && !sclkPrev && !portSelectLow;
    wire sclkFall = !serialShiftClock && sclkPrev && !portSelectLow;

    // ----------------------------------------
    // frame sequencer
    // ----------------------------------------
    asr_pkg::asr_state_t state;
    logic [3:0] bitCnt;
    logic [14:0] instrSr;
    logic [6:0] dataSr;
    logic isRead;
    logic [12:0] addr;
    logic loadTx;
    logic wrStrobe;
    logic [12:0] wrAddr;
    logic [7:0] wrData;
    wire instrDone = (state == asr_pkg::ASR_INSTR) && sclkRise && (bitCnt == `ASR_INSTR_LAST);
    wire byteDone = (state == asr_pkg::ASR_DATA) && sclkRise && (bitCnt == `ASR_BYTE_LAST);
    wire [12:0] next_addr = instrDone ? {instrSr[11:0], sharedSerialLineIn} : addr + `ASR_ADDR_STEP;

    always_ff @(posedge mclk or negedge rstSync_b) begin
        if (!rstSync_b)
            state <= asr_pkg::ASR_IDLE;
        else if (portSelectLow)
            state <= asr_pkg::ASR_IDLE;
        else begin
            unique case (state)
                asr_pkg::ASR_IDLE: state <= asr_pkg::ASR_INSTR;
                asr_pkg::ASR_INSTR: if (instrDone) state <= asr_pkg::ASR_DATA;
                asr_pkg::ASR_DATA: state <= asr_pkg::ASR_DATA;
                default: state <= asr_pkg::ASR_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstSync_b) begin
        if (!rstSync_b)
            bitCnt <= `ASR_CNT_ZERO;
        else if (state == asr_pkg::ASR_IDLE || instrDone || byteDone)
            bitCnt <= `ASR_CNT_ZERO;
        else if (sclkRise)
            bitCnt <= bitCnt + `ASR_CNT_STEP;
    end

    always_ff @(posedge mclk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            instrSr <= '0;
            dataSr <= '0;
        end else if (sclkRise) begin
            instrSr <= {instrSr[13:0], sharedSerialLineIn};
            dataSr <= {dataSr[5:0], sharedSerialLineIn};
        end
    end

    always_ff @(posedge mclk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            isRead <= 1'b0;
            addr <= '0;
        end else if (instrDone || byteDone) begin
            if (instrDone)
                isRead <= instrSr[`ASR_RW_POS];
            addr <= next_addr;
        end
    end

    // writes are committed one cycle after the last data bit of each byte
    always_ff @(posedge mclk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            wrStrobe <= 1'b0;
            wrAddr <= '0;
            wrData <= '0;
        end else begin
            wrStrobe <= byteDone && !isRead;
            if (byteDone) begin
                wrAddr <= addr;
                wrData <= {dataSr, sharedSerialLineIn};
            end
        end
    end

    // ----------------------------------------
    // register file
    // ----------------------------------------
    logic softPending;
    wire wrPortCfg = wrStrobe && (wrAddr == `ASR_ADDR_PORTCFG);
    wire wrChSel = wrStrobe && (wrAddr == `ASR_ADDR_CHSEL);
    wire wrLocal = wrStrobe && (wrAddr == `ASR_ADDR_LOCAL);
    wire softReq = wrPortCfg && (wrData[`ASR_SOFT_HI] || wrData[`ASR_SOFT_LO]);
    wire lsbReq = wrData[`ASR_LSB_HI] || wrData[`ASR_LSB_LO];

    always_ff @(posedge mclk or negedge rstSync_b) begin
        if (!rstSync_b)
            softPending <= 1'b0;
        else
            softPending <= softReq;
    end

    // global register: no selection term in its write decode
    always_ff @(posedge mclk or negedge rstSync_b) begin
        if (!rstSync_b)
            lsbFirst <= 1'b0;
        else if (softPending)
            lsbFirst <= 1'b0;
        else if (wrPortCfg)
            lsbFirst <= lsbReq;
    end

    always_ff @(posedge mclk or negedge rstSync_b) begin
        if (!rstSync_b)
            channelSelect <= `ASR_CHSEL_RST;
        else if (softPending)
            channelSelect <= `ASR_CHSEL_RST;
        else if (wrChSel)
            channelSelect <= wrData & `ASR_CHSEL_MASK;
    end

    // soft reset bits are not stored and always read back as zero
    wire [7:0] portCfgRd = `ASR_PORTCFG_RST | ({7'h00, lsbFirst} << `ASR_LSB_HI)
                         | ({7'h00, lsbFirst} << `ASR_LSB_LO);
    wire [7:0] gradeRd = {5'h00, SPEED_GRADE} << `ASR_GRADE_LSB;

    asr_local_if lcl ();
    assign lcl.wrLocal = wrLocal;
    assign lcl.wrData = wrData;
    assign lcl.softRst = softPending;
    assign lcl.selVec = {channelSelect[`ASR_SEL_DATA_CLK], channelSelect[`ASR_SEL_FRAME_CLK],
                         channelSelect[`ASR_SEL_B], channelSelect[`ASR_SEL_A]};

    asr_local_bank u_bank (
        .mclk(mclk),
        .rstSync_b(rstSync_b),
        .lcl(lcl),
        .copies(channelSetup)
    );

    wire [7:0] rdData = (addr == `ASR_ADDR_PORTCFG) ? portCfgRd :
                        (addr == `ASR_ADDR_PARTID) ? PART_ID :
                        (addr == `ASR_ADDR_GRADE) ? gradeRd :
                        (addr == `ASR_ADDR_CHSEL) ? channelSelect :
                        (addr == `ASR_ADDR_LOCAL) ? lcl.rdData : `ASR_ZERO_BYTE;

    // ----------------------------------------
    // readback shifter
    // ----------------------------------------
    logic [7:0] txByte;
    always_ff @(posedge mclk or negedge rstSync_b) begin
        if (!rstSync_b)
            loadTx <= 1'b0;
        else
            loadTx <= instrDone || byteDone;
    end

    always_ff @(posedge mclk or negedge rstSync_b) begin
        if (!rstSync_b)
            txByte <= '0;
        else if (loadTx)
            txByte <= rdData;
        else if (sclkFall && isRead && state == asr_pkg::ASR_DATA)
            txByte <= {txByte[6:0], 1'b0};
    end

    // line is released whenever the port is deselected
    always_ff @(posedge mclk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            sharedSerialLineOut <= 1'b0;
            sharedSerialLineOeN <= 1'b1;
        end else if (portSelectLow || state != asr_pkg::ASR_DATA || !isRead) begin
            sharedSerialLineOut <= 1'b0;
            sharedSerialLineOeN <= 1'b1;
        end else if (sclkFall) begin
            sharedSerialLineOut <= txByte[7];
            sharedSerialLineOeN <= 1'b0;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstSync_b);

    AST_SOFT_DEFAULTS: assert property (
        softReq |=> ##1 channelSelect == `ASR_CHSEL_RST && !lsbFirst && !softPending)
        else $error("soft reset did not restore defaults");
    AST_SOFT_CLEARS: assert property (
        softPending |=> !softPending && portCfgRd[`ASR_SOFT_HI] == 1'b0)
        else $error("soft reset bit stuck");
    AST_CHSEL_HOLD: assert property (
        !wrChSel && !softPending |=> $stable(channelSelect))
        else $error("channel selection changed without a write");
    AST_CHSEL_WRITE: assert property (
        wrChSel && !softPending |=> channelSelect == ($past(wrData) & `ASR_CHSEL_MASK))
        else $error("channel selection write lost");
    AST_PORTCFG_FIXED: assert property (
        portCfgRd[7] == 1'b0 && portCfgRd[0] == 1'b0 && portCfgRd[4] && portCfgRd[3]
            && portCfgRd[6] == portCfgRd[1])
        else $error("port setup fixed bits wrong");
    AST_GLOBAL_UNGATED: assert property (
        wrPortCfg && !softPending && channelSelect == `ASR_ZERO_BYTE |=> lsbFirst == $past(lsbReq))
        else $error("global write gated by selection");
    AST_READ_DIR: assert property (
        !sharedSerialLineOeN |-> isRead && state == asr_pkg::ASR_DATA)
        else $error("line driven outside read data phase");
    AST_READ_TURN: assert property (
        state == asr_pkg::ASR_DATA && isRead && sclkFall && !portSelectLow
            |=> !sharedSerialLineOeN)
        else $error("read did not turn the line around");
    AST_WRITE_PHASE: assert property (
        wrStrobe |-> !isRead)
        else $error("write committed during a read frame");
endmodule // asr_spi_regs
`default_nettype wire

// ### dv/asr_host_model.sv
/*
 * Host side of the 3-wire serial port: frames, bit shifting, line release.
 * Assumes a free-running mclk and a bench that resolves the shared line.
 */
`timescale 1ns/100ps
`default_nettype none
module asr_host_model (
    input wire logic mclk,
    input wire logic lineLevel,
    output logic sclk,
    output logic portSelectLow,
    output logic hostDrive,
    output logic hostBit
);
    // ----------------------------------------
    // frame tasks
    // ----------------------------------------
    // sclk stands low between frames; levels last 3 or more mclk, above the minimum of 2
    initial begin
        sclk = 1'b0;
        portSelectLow = 1'b1;
        hostDrive = 1'b0;
        hostBit = 1'b0;
    end
    task automatic half(input logic lvl);
        @(posedge mclk);
        sclk <= lvl;
        repeat (2) @(posedge mclk);
    endtask
    task automatic send_bit(input logic b);
        @(posedge mclk);
        hostBit <= b;
        sclk <= 1'b0;
        repeat (2) @(posedge mclk);
        half(1'b1);
    endtask
    // callers pass mapped addresses, except one read of 13'h0013, and zero the open bits of written values
    task automatic xfer(input logic rd, input logic [12:0] addr, input logic [7:0] wr,
            output logic [7:0] got);
        logic [15:0] ins;
        ins = {rd, 2'h0, addr};
        got = 8'h00;
        @(posedge mclk);
        portSelectLow <= 1'b0;
        hostDrive <= 1'b1;
        repeat (2) @(posedge mclk);
        for (int i = 15; i >= 0; i--) send_bit(ins[i]);
        for (int i = 7; i >= 0; i--) begin
            if (rd) begin
                @(posedge mclk);
                hostDrive <= 1'b0;
                sclk <= 1'b0;
                repeat (4) @(posedge mclk);
                @(negedge mclk);
                got[i] = lineLevel;
                half(1'b1);
            end else begin
                send_bit(wr[i]);
            end
        end
        half(1'b0);
        portSelectLow <= 1'b1;
        hostDrive <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask
endmodule // asr_host_model
`default_nettype wire

// ### dv/test_asr_spi_regs.sv
/*
 * Self-checking bench of the register bank through its serial port.
 * Assumes asr_cfg.svh on the include path and the host model beside it.
 */
`timescale 1ns/100ps
`default_nettype none
`include "asr_cfg.svh"
module test_asr_spi_regs;
    localparam logic [7:0] PART = 8'hC3; // arbitrary value
    localparam logic [2:0] GRADE = 3'h5; // arbitrary value
    logic mclk, rst_b, sclk, portSelectLow, hostDrive, hostBit, lastLine, lineOut, lineOeN;
    logic lsbFirst;
    logic [7:0] channelSelect, got;
    logic [3:0][7:0] channelSetup;
    logic [31:0] expSet;
    logic [7:0] selTab [4] = '{8'h01, 8'h02, 8'h10, 8'h20};
    logic [7:0] valTab [4] = '{8'h11, 8'h22, 8'h44, 8'h88};
    int bad_count, num_checks;
    wire lineLevel;
    // released line shows the inverse of its last level, so stale data cannot pass
    assign lineLevel = (lineOeN === 1'b0) ? lineOut : (hostDrive ? hostBit : ~lastLine);
    always #4 mclk = ~mclk;
    always @(posedge mclk) lastLine <= lineLevel;
    asr_host_model host (.mclk(mclk), .lineLevel(lineLevel), .sclk(sclk),
        .portSelectLow(portSelectLow), .hostDrive(hostDrive), .hostBit(hostBit));
    asr_spi_regs #(.PART_ID(PART), .SPEED_GRADE(GRADE)) dut (.mclk(mclk), .rst_b(rst_b),
        .serialShiftClock(sclk), .portSelectLow(portSelectLow),
        .sharedSerialLineIn(lineLevel), .sharedSerialLineOut(lineOut),
        .sharedSerialLineOeN(lineOeN), .channelSelect(channelSelect),
        .lsbFirst(lsbFirst), .channelSetup(channelSetup));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [12:0] a, input logic [7:0] v);
        host.xfer(1'b0, a, v, got);
    endtask
    task automatic rdchk(input string what, input logic [12:0] a, input logic [7:0] exp);
        host.xfer(1'b1, a, 8'h00, got);
        chk(what, exp, got);
    endtask
    task automatic copies(input logic [31:0] exp);
        for (int i = 0; i < 4; i++) chk("setup copy", exp[i*8+:8], channelSetup[i]);
    endtask
    task automatic do_reset();
        rst_b <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (4) @(posedge mclk);
    endtask
    task automatic dflt();
        chk("channel select", 8'h33, channelSelect);
        chk("lsb first", 8'h00, {7'h0, lsbFirst});
        chk("line enable", 8'h01, {7'h0, lineOeN});
        copies(32'h0);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        #(20000 * 8);
        bad_count++;
        results();
    end
    initial begin
        mclk = 1'b0;
        rst_b = 1'b0;
        lastLine = 1'b0;
        bad_count = 0;
        num_checks = 0;
        do_reset();
        dflt();
        rdchk("port setup", `ASR_ADDR_PORTCFG, 8'h18);
        rdchk("channel select", `ASR_ADDR_CHSEL, 8'h33);
        rdchk("part id", `ASR_ADDR_PARTID, PART);
        rdchk("grade", `ASR_ADDR_GRADE, {1'b0, GRADE, 4'h0});
        rdchk("open place", 13'h0013, 8'h00);
        $display("test defaults done");
        wr(`ASR_ADDR_LOCAL, 8'hA5);
        expSet = {4{8'hA5}};
        copies(expSet);
        for (int i = 0; i < 4; i++) begin
            wr(`ASR_ADDR_CHSEL, selTab[i]);
            wr(`ASR_ADDR_LOCAL, valTab[i]);
            expSet[i*8+:8] = valTab[i];
            copies(expSet);
        end
        $display("test local copies done");
        wr(`ASR_ADDR_CHSEL, 8'h33);
        rdchk("broadcast read", `ASR_ADDR_LOCAL, 8'h11);
        wr(`ASR_ADDR_CHSEL, 8'h02);
        rdchk("read b", `ASR_ADDR_LOCAL, 8'h22);
        rdchk("part id", `ASR_ADDR_PARTID, PART);
        rdchk("read b again", `ASR_ADDR_LOCAL, 8'h22);
        chk("channel select", 8'h02, channelSelect);
        $display("test local reads done");
        wr(`ASR_ADDR_CHSEL, 8'h00);
        wr(`ASR_ADDR_PORTCFG, 8'h5A);
        chk("lsb first", 8'h01, {7'h0, lsbFirst});
        rdchk("port setup", `ASR_ADDR_PORTCFG, 8'h5A);
        wr(`ASR_ADDR_PARTID, 8'hFF);
        rdchk("part id", `ASR_ADDR_PARTID, PART);
        $display("test global done");
        wr(`ASR_ADDR_CHSEL, 8'h10);
        wr(`ASR_ADDR_PORTCFG, 8'h3C);
        dflt();
        rdchk("port setup", `ASR_ADDR_PORTCFG, 8'h18);
        $display("test soft reset done");
        wr(`ASR_ADDR_CHSEL, 8'h01);
        wr(`ASR_ADDR_LOCAL, 8'h77);
        do_reset();
        dflt();
        $display("test second reset done");
        results();
    end
endmodule // test_asr_spi_regs
`default_nettype wire
